// ### srw_defines.svh
// constants for the serial register writer
`ifndef SRW_DEFINES_SVH
`define SRW_DEFINES_SVH

// --------------------------------------------------------------
// bus framing
// --------------------------------------------------------------
`define SRW_ADDR_HI    5'h16
`define SRW_BYTE_BITS  4'h8

// --------------------------------------------------------------
// subaddress map
// --------------------------------------------------------------
`define SRW_NREGS      25
`define SRW_LAST_SUB   8'h18
`define SRW_PRESET_SUB 8'hff
`define SRW_PTR_VOID   9'h100
`define SRW_FC1_A      8'h03
`define SRW_FC1_B      8'h04
`define SRW_FC1_C      8'h05
`define SRW_FC2_A      8'h06
`define SRW_FC2_B      8'h07
`define SRW_FC2_C      8'h08
`define SRW_PRE_FIRST  5'h03
`define SRW_PRE_LAST   5'h0a
`define SRW_LVL_C1     8'h0c
`define SRW_LVL_C2     8'h0d
`define SRW_LVL_NIC    8'h0f
`define SRW_LVL_I2S    8'h17
`define SRW_LVL_MAX    8'h1f

`endif

// ### srw_pkg.sv
// types shared by the serial register writer
package srw_pkg;
   // byte position of the receiver
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SUB, ST_DATA, ST_ACK, ST_SKIP} srw_state_e;

   // one write into the register store
   typedef struct packed {
      logic       we;
      logic [4:0] idx;
      logic [7:0] data;
   } srw_wr_s;
endpackage : srw_pkg

// ### srw_regmem.sv
// register store with one write port and a registered read port
`timescale 1ns/1ns
module srw_regmem #(
   parameter int DEPTH = 25
) (
   // clock and reset
   input  wire logic            clk_sys,
   input  wire logic            rst,
   // write port
   input  wire srw_pkg::srw_wr_s wr,
   // read port
   input  wire logic [4:0]      rd_idx,
   output logic [7:0]           rd_data
);
   import srw_pkg::*;

   logic [7:0] mem_r [DEPTH];

   // --------------------------------------------------------------
   // storage, one entry each
   // --------------------------------------------------------------
   for (genvar g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            mem_r[g] <= 8'h00;
         end else if (wr.we && (wr.idx == 5'(g))) begin
            mem_r[g] <= wr.data;
         end
      end
   end

   // registered read, unmapped index reads zero
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (rd_idx < 5'(DEPTH)) begin
         rd_data <= mem_r[rd_idx];
      end else begin
         rd_data <= 8'h00;
      end
   end
endmodule : srw_regmem

// ### srw_writer.sv
// two-wire bus slave that writes the control registers
`timescale 1ns/1ns
`include "srw_defines.svh"
module srw_writer #(
   parameter int NREGS = `SRW_NREGS
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // serial bus pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   // address straps
   input  wire logic       addr_select_low_pin,
   input  wire logic       addr_select_high_pin,
   // register readout to the decoder core
   input  wire logic [4:0] rd_idx,
   output logic [7:0]      rd_data,
   output logic [7:0]      standard_preset_r,
   // events
   output logic            upd_pulse_r,
   output logic            bus_error_r
);
   import srw_pkg::*;

   // --------------------------------------------------------------
   // input synchronisers and bus conditions
   // --------------------------------------------------------------
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic       scl_d_r;
   logic       sda_d_r;

   // two flops on every pin, history read from the second only
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_r <= 4'hf;
         sync2_r <= 4'hf;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         sync1_r <= {addr_select_high_pin, addr_select_low_pin, sda_i, scl_i};
         sync2_r <= sync1_r;
         scl_d_r <= sync2_r[0];
         sda_d_r <= sync2_r[1];
      end
   end

   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic cond_start;
   logic cond_stop;
   assign scl        = sync2_r[0];
   assign sda        = sync2_r[1];
   assign scl_rise   = scl & ~scl_d_r;
   assign scl_fall   = ~scl & scl_d_r;
   assign cond_start = scl & scl_d_r & sda_d_r & ~sda;
   assign cond_stop  = scl & scl_d_r & ~sda_d_r & sda;

   // --------------------------------------------------------------
   // byte receiver state
   // --------------------------------------------------------------
   srw_state_e st_r;
   srw_state_e nxt_r;
   logic [3:0] cnt_r;
   logic [7:0] shreg_r;
   logic [7:0] byte_r;
   logic [8:0] ptr_r;
   logic       pend_r;

   // byte classification
   logic [7:0] sub8;
   logic       sub_exists;
   logic       is_level;
   logic       data_ok;
   logic       addr_ok;
   assign sub8       = ptr_r[7:0];
   assign sub_exists = ~ptr_r[8] & ((sub8 <= `SRW_LAST_SUB) |
                       (sub8 == `SRW_PRESET_SUB));
   assign is_level   = (sub8 == `SRW_LVL_C1) | (sub8 == `SRW_LVL_C2) |
                       (sub8 == `SRW_LVL_NIC) | (sub8 == `SRW_LVL_I2S);
   assign data_ok    = sub_exists & (~is_level | (shreg_r <= `SRW_LVL_MAX));
   // write address only; all zeros never matches the fixed upper bits
   assign addr_ok    = (shreg_r == {`SRW_ADDR_HI, sync2_r[3], sync2_r[2], 1'b0});

   logic byte_done;
   logic exec;
   assign byte_done = scl_fall & (cnt_r == `SRW_BYTE_BITS);
   // a byte executes only on the acknowledge clock, so a stop before it drops it
   assign exec      = scl_rise & (st_r == ST_ACK) & pend_r;

   // frame sequencing; bus stays live in every core mode
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r    <= ST_IDLE;
         nxt_r   <= ST_IDLE;
         cnt_r   <= 4'h0;
         shreg_r <= 8'h00;
         byte_r  <= 8'h00;
         pend_r  <= 1'b0;
      end else if (cond_start) begin
         st_r   <= ST_ADDR;
         cnt_r  <= 4'h0;
         pend_r <= 1'b0;
      end else if (cond_stop) begin
         st_r   <= ST_IDLE;
         cnt_r  <= 4'h0;
         pend_r <= 1'b0;
      end else begin
         case (st_r)
            ST_ADDR, ST_SUB, ST_DATA: begin
               if (scl_rise) begin
                  shreg_r <= {shreg_r[6:0], sda};
                  cnt_r   <= cnt_r + 4'h1;
               end else if (byte_done) begin
                  cnt_r  <= 4'h0;
                  byte_r <= shreg_r;
                  st_r   <= ST_ACK;
                  if (st_r == ST_ADDR) begin
                     pend_r <= 1'b0;
                     nxt_r  <= addr_ok ? ST_SUB : ST_SKIP;
                  end else if (st_r == ST_SUB) begin
                     pend_r <= 1'b0;
                     nxt_r  <= ST_DATA;
                  end else begin
                     pend_r <= data_ok;
                     nxt_r  <= data_ok ? ST_DATA : ST_SKIP;
                  end
               end
            end
            ST_ACK: begin
               if (scl_rise) begin
                  pend_r <= 1'b0;
               end else if (scl_fall) begin
                  st_r <= nxt_r;
               end
            end
            ST_IDLE, ST_SKIP: begin
               cnt_r <= 4'h0;
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

   // subaddress pointer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ptr_r <= 9'h000;
      end else if (byte_done && st_r == ST_SUB) begin
         ptr_r <= {1'b0, shreg_r};
      end else if (exec) begin
         // preset is the top subaddress, the step after it is void
         ptr_r <= ptr_r + 9'h001;
      end
   end

   // acknowledge drive, held from the byte end to the next falling clock
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sda_oe <= 1'b0;
         sda_o  <= 1'b0;
      end else if (cond_start || cond_stop) begin
         sda_oe <= 1'b0;
      end else if (byte_done && st_r != ST_IDLE && st_r != ST_SKIP) begin
         sda_oe <= (st_r == ST_ADDR) ? addr_ok :
                   (st_r == ST_SUB)  ? 1'b1 : data_ok;
      end else if (scl_fall && st_r == ST_ACK) begin
         sda_oe <= 1'b0;
      end
   end

   // stop in mid byte or before the acknowledge clock; the clock rise
   // of a clean stop shifts one bit, so one bit alone is no error
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_error_r <= 1'b0;
      end else begin
         bus_error_r <= cond_stop & ((cnt_r > 4'h1) | pend_r);
      end
   end

   // --------------------------------------------------------------
   // staging of multi-byte functions and the write engine
   // --------------------------------------------------------------
   logic [7:0] stg_r [3];
   logic [1:0] stg_vld_r;
   logic       stg_grp_r;
   logic       eng_busy_r;
   logic       eng_pre_r;
   logic [4:0] eng_idx_r;
   logic [4:0] eng_base_r;
   logic [4:0] eng_last_r;
   logic       start_eng;
   logic [4:0] start_base;
   logic [4:0] start_last;
   logic       start_pre;
   logic       grp2;

   assign grp2 = (sub8 >= `SRW_FC2_A);

   // decode what an executed byte does
   always_comb begin
      start_eng  = 1'b0;
      start_pre  = 1'b0;
      start_base = sub8[4:0];
      start_last = sub8[4:0];
      if (exec) begin
         if (sub8 == `SRW_PRESET_SUB) begin
            start_eng  = 1'b1;
            start_pre  = 1'b1;
            start_base = `SRW_PRE_FIRST;
            start_last = `SRW_PRE_LAST;
         end else if (sub8 == `SRW_FC1_C || sub8 == `SRW_FC2_C) begin
            start_eng  = (stg_vld_r == 2'b11) && (stg_grp_r == grp2);
            start_base = sub8[4:0] - 5'h02;
         end else if (sub8 != `SRW_FC1_A && sub8 != `SRW_FC1_B &&
                      sub8 != `SRW_FC2_A && sub8 != `SRW_FC2_B) begin
            start_eng  = 1'b1;
         end
      end
   end

   // staging bytes; start and stop drop an incomplete function
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stg_vld_r <= 2'b00;
         stg_grp_r <= 1'b0;
         stg_r[0]  <= 8'h00;
         stg_r[1]  <= 8'h00;
         stg_r[2]  <= 8'h00;
      end else if (cond_start || cond_stop) begin
         stg_vld_r <= 2'b00;
      end else if (exec) begin
         if (sub8 == `SRW_FC1_A || sub8 == `SRW_FC2_A) begin
            stg_r[0]  <= byte_r;
            stg_vld_r <= 2'b01;
            stg_grp_r <= grp2;
         end else if (sub8 == `SRW_FC1_B || sub8 == `SRW_FC2_B) begin
            stg_r[1]     <= byte_r;
            stg_vld_r[1] <= stg_vld_r[0] & (stg_grp_r == grp2);
         end else if (sub8 == `SRW_FC1_C || sub8 == `SRW_FC2_C) begin
            stg_r[2]  <= byte_r;
            stg_vld_r <= 2'b00;
         end else if (sub8 != `SRW_PRESET_SUB) begin
            stg_r[0]  <= byte_r;
         end
      end
   end

   // preset register held apart from the store
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         standard_preset_r <= 8'h00;
      end else if (exec && sub8 == `SRW_PRESET_SUB) begin
         standard_preset_r <= byte_r;
      end
   end

   // engine walks base..last, one register per cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         eng_busy_r  <= 1'b0;
         eng_pre_r   <= 1'b0;
         eng_idx_r   <= 5'h00;
         eng_base_r  <= 5'h00;
         eng_last_r  <= 5'h00;
         upd_pulse_r <= 1'b0;
      end else if (start_eng) begin
         eng_busy_r  <= 1'b1;
         eng_pre_r   <= start_pre;
         eng_idx_r   <= start_base;
         eng_base_r  <= start_base;
         eng_last_r  <= start_last;
         upd_pulse_r <= 1'b0;
      end else if (eng_busy_r) begin
         eng_idx_r   <= eng_idx_r + 5'h01;
         eng_busy_r  <= (eng_idx_r != eng_last_r);
         upd_pulse_r <= (eng_idx_r == eng_last_r);
      end else begin
         upd_pulse_r <= 1'b0;
      end
   end

   // write data: preset pattern or staged bytes
   srw_wr_s    wr;
   logic [4:0] stg_off;
   assign stg_off  = eng_idx_r - eng_base_r;
   assign wr.we    = eng_busy_r;
   assign wr.idx   = eng_idx_r;
   assign wr.data  = eng_pre_r ? {standard_preset_r[3:0], eng_idx_r[3:0]}
                               : stg_r[stg_off[1:0]];

   // --------------------------------------------------------------
   // register store
   // --------------------------------------------------------------
   srw_regmem #(
      .DEPTH (NREGS)
   ) u_mem (
      .clk_sys (clk_sys),
      .rst     (rst),
      .wr      (wr),
      .rd_idx  (rd_idx),
      .rd_data (rd_data)
   );
endmodule : srw_writer

// ### srw_writer_props.sv
// concurrent checks on the serial register writer ports
`timescale 1ns/1ns
module srw_writer_props #(
   parameter int NREGS = 25
) (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       rst,
   // serial bus pins
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   // address straps
   input wire logic       addr_select_low_pin,
   input wire logic       addr_select_high_pin,
   // register readout
   input wire logic [4:0] rd_idx,
   input wire logic [7:0] rd_data,
   input wire logic [7:0] standard_preset_r,
   // events
   input wire logic       upd_pulse_r,
   input wire logic       bus_error_r
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------
   // sequences
   // ----------------------------------------------------------
   sequence s_err_once;
      bus_error_r ##1 !bus_error_r;
   endsequence
   sequence s_no_exec;
      !upd_pulse_r ##1 !upd_pulse_r;
   endsequence

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   a_drive_zero: assert property (sda_o == 1'b0)
      else $error("sda drive value not low");
   a_reset_clears: assert property (disable iff (1'b0) $fell(rst) |-> !sda_oe &&
      !upd_pulse_r && !bus_error_r && standard_preset_r == 8'h00)
      else $error("outputs not cleared by reset");
   a_ack_rise_low: assert property ($rose(sda_oe) |-> !scl_i)
      else $error("ack driven while bus clock high");
   a_ack_fall_low: assert property ($fell(sda_oe) |-> !scl_i)
      else $error("ack released while bus clock high");
   a_upd_in_ack: assert property (upd_pulse_r |-> sda_oe)
      else $error("update outside an acked byte");
   a_upd_one_cycle: assert property (upd_pulse_r |=> !upd_pulse_r)
      else $error("update pulse too long");
   a_err_one_cycle: assert property (bus_error_r |-> s_err_once)
      else $error("bus error pulse too long");
   a_err_no_exec: assert property (bus_error_r |-> s_no_exec)
      else $error("operation executed on bus error");
   a_err_after_stop: assert property (bus_error_r |-> scl_i && sda_i)
      else $error("bus error without stop state");
   a_preset_in_ack: assert property ($changed(standard_preset_r) |-> sda_oe)
      else $error("preset changed outside ack");
endmodule : srw_writer_props

bind srw_writer srw_writer_props #(.NREGS(NREGS)) u_props (
   .clk_sys(clk_sys), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe(sda_oe), .addr_select_low_pin(addr_select_low_pin),
   .addr_select_high_pin(addr_select_high_pin), .rd_idx(rd_idx), .rd_data(rd_data),
   .standard_preset_r(standard_preset_r), .upd_pulse_r(upd_pulse_r),
   .bus_error_r(bus_error_r));

// ### srw_host_model.sv
// two-wire bus master model that sends write frames
`timescale 1ns/1ns
module srw_host_model #(
   parameter int QTR = 13
) (
   // clock
   input wire logic clk_sys,
   // serial bus
   input wire logic sda,
   output logic     scl,
   output logic     sda_low
);
   // idle bus, both lines released
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   // quarter bit, four quarters keep the rate under 400 kbit/s
   task q;
      repeat (QTR) @(negedge clk_sys);
   endtask : q

   // start or repeated start, data falls while clock high
   task start;
      sda_low = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask : start

   // n bits msb first, then the ack clock when the byte is whole
   task send(input logic [7:0] d, input int n, output logic ack);
      ack = 1'b0;
      for (int i = 0; i < n; i++) begin
         sda_low = !d[7-i];
         q();
         scl = 1'b1;
         q();
         q();
         scl = 1'b0;
         q();
      end
      if (n == 8) begin
         sda_low = 1'b0;
         q();
         scl = 1'b1;
         q();
         ack = !sda;
         q();
         scl = 1'b0;
         q();
      end
   endtask : send

   // stop, data rises while clock high
   task stop;
      sda_low = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b0;
      q();
   endtask : stop
endmodule : srw_host_model

// ### tb_i2c_slave_register_writer.sv
// self-checking bench for the serial register writer
`timescale 1ns/1ns
`include "srw_defines.svh"
`define TB_CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin error_cnt++; \
   $display("Error t=%0t act=%h exp=%h", $time, act, exp); end end
module tb_i2c_slave_register_writer;
   logic       clk_sys, rst, a_lo, a_hi, scl, sda_low, sda_o, sda_oe;
   logic       upd, berr, sda;
   logic [4:0] rd_idx;
   logic [7:0] rd_data, preset, ak;
   int         error_cnt, check_count, err_seen, upd_seen, cyc;

   // wired-and bus with pull-up
   assign sda = !(sda_low || (sda_oe && !sda_o));

   srw_writer i_dut (.clk_sys(clk_sys), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .addr_select_low_pin(a_lo), .addr_select_high_pin(a_hi),
      .rd_idx(rd_idx), .rd_data(rd_data), .standard_preset_r(preset),
      .upd_pulse_r(upd), .bus_error_r(berr));
   srw_host_model u_host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // event pulse counters and run limit
   always @(posedge clk_sys) begin
      if (berr === 1'b1) err_seen++;
      if (upd === 1'b1) upd_seen++;
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         summarize();
      end
   end

   task summarize;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   // whole write frame, ends early on a refused data byte
   task wr(input logic [7:0] sub, input logic [7:0] d[$], output logic [7:0] k);
      logic a;
      k = 8'h00;
      u_host.start();
      u_host.send({`SRW_ADDR_HI, a_hi, a_lo, 1'b0}, 8, a);
      u_host.send(sub, 8, a);
      foreach (d[i]) begin
         u_host.send(d[i], 8, a);
         k[i] = a;
         if (!a) break;
      end
      u_host.stop();
   endtask : wr

   task rd(input logic [4:0] idx, input logic [7:0] exp);
      rd_idx = idx;
      repeat (2) @(negedge clk_sys);
      `TB_CHK(rd_data, exp)
   endtask : rd

   task t_basic;
      wr(8'h00, '{8'h5a}, ak);
      `TB_CHK(ak, 8'h01)
      rd(5'h00, 8'h5a);
      wr(8'h16, '{8'h11, 8'h1f, 8'h33, 8'h44}, ak);
      `TB_CHK(ak, 8'h07)
      rd(5'h16, 8'h11);
      rd(5'h17, 8'h1f);
      rd(5'h18, 8'h33);
      wr(8'h0c, '{8'h20}, ak);
      `TB_CHK(ak, 8'h00)
      rd(5'h0c, 8'h00);
      wr(8'h0c, '{8'h1f}, ak);
      rd(5'h0c, 8'h1f);
   endtask : t_basic

   task t_group;
      int u0;
      u0 = upd_seen;
      wr(8'h03, '{8'ha1, 8'ha2}, ak);
      `TB_CHK(ak, 8'h03)
      rd(5'h03, 8'h00);
      wr(8'h04, '{8'hb1, 8'hb2}, ak);
      rd(5'h05, 8'h00);
      wr(8'h03, '{8'hc1, 8'hc2, 8'hc3}, ak);
      rd(5'h03, 8'hc1);
      rd(5'h05, 8'hc3);
      `TB_CHK(upd_seen, u0 + 1)
   endtask : t_group

   // preset pattern on 3..10, then 0x0c and 0x0e left as written
   task t_preset;
      wr(8'h0e, '{8'h04}, ak);
      wr(8'hff, '{8'h07}, ak);
      `TB_CHK(preset, 8'h07)
      for (int i = 3; i <= 10; i++) rd(i[4:0], {4'h7, i[3:0]});
      rd(5'h0c, 8'h1f);
      rd(5'h0e, 8'h04);
   endtask : t_preset

   task t_addr;
      logic       a;
      logic [7:0] bad [3];
      for (int k = 0; k < 4; k++) begin
         {a_hi, a_lo} = k[1:0];
         repeat (4) @(negedge clk_sys);
         wr(8'h01, '{8'h40 + k[7:0]}, ak);
         rd(5'h01, 8'h40 + k[7:0]);
      end
      bad[0] = 8'h00;
      bad[1] = {`SRW_ADDR_HI, !a_hi, a_lo, 1'b0};
      bad[2] = {`SRW_ADDR_HI, a_hi, a_lo, 1'b1};
      foreach (bad[i]) begin
         u_host.start();
         u_host.send(bad[i], 8, a);
         u_host.stop();
         `TB_CHK(a, 1'b0)
      end
   endtask : t_addr

   task t_abort;
      logic a;
      int   e0;
      for (int n = 3; n <= 7; n += 4) begin
         e0 = err_seen;
         u_host.start();
         u_host.send({`SRW_ADDR_HI, a_hi, a_lo, 1'b0}, 8, a);
         u_host.send(8'h02, 8, a);
         u_host.send(8'h99, n, a);
         u_host.stop();
         repeat (8) @(negedge clk_sys);
         `TB_CHK(err_seen, e0 + 1)
      end
      rd(5'h02, 8'h00);
      e0 = err_seen;
      u_host.start();
      u_host.send({`SRW_ADDR_HI, a_hi, a_lo, 1'b0}, 8, a);
      u_host.send(8'h13, 8, a);
      u_host.send(8'h55, 3, a);
      wr(8'h14, '{8'h66}, ak);
      `TB_CHK(err_seen, e0)
      rd(5'h14, 8'h66);
      rd(5'h13, 8'h00);
   endtask : t_abort

   initial begin
      rst    = 1'b1;
      a_lo   = 1'b0;
      a_hi   = 1'b0;
      rd_idx = 5'h00;
      repeat (20) @(negedge clk_sys);
      rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      rd(5'h18, 8'h00);
      t_basic();
      t_group();
      t_preset();
      t_addr();
      t_abort();
      summarize();
   end
endmodule : tb_i2c_slave_register_writer
